// [design/crf_pkg.sv]
package crf_pkg;
  // widths
  localparam int          DATA_W      = 16;
  localparam int          PAGE_W      = 8;
  localparam int          AXI_AW      = 8;
  localparam int          NUM_GPR     = 8;
  localparam int          NUM_PAGE    = 4;

  // register byte offsets on the bus
  localparam logic [7:0]  OFF_GPR0    = 8'h00;
  localparam logic [7:0]  OFF_PC      = 8'h20;
  localparam logic [7:0]  OFF_SR      = 8'h24;
  localparam logic [7:0]  OFF_CODE_PG = 8'h28;
  localparam logic [7:0]  OFF_DATA_PG = 8'h2C;
  localparam logic [7:0]  OFF_EXT_PG  = 8'h30;
  localparam logic [7:0]  OFF_STK_PG  = 8'h34;
  localparam logic [7:0]  OFF_BASE    = 8'h38;
  localparam logic [7:0]  OFF_MODE    = 8'h3C;

  // page register indices
  localparam logic [1:0]  PG_CODE     = 2'h0;
  localparam logic [1:0]  PG_DATA     = 2'h1;
  localparam logic [1:0]  PG_EXT      = 2'h2;
  localparam logic [1:0]  PG_STACK    = 2'h3;

  // status word layout
  localparam int          SR_TRACE    = 15;
  localparam int          SR_MASK_LO  = 8;
  localparam int          SR_N        = 3;
  localparam int          SR_Z        = 2;
  localparam int          SR_V        = 1;
  localparam int          SR_C        = 0;
  localparam logic [15:0] SR_WMASK    = 16'h870F;
  localparam logic [15:0] SR_RESET    = 16'h0700;
  localparam logic [2:0]  MASK_ALL    = 3'h7;

  // implicit pointer roles and step
  localparam logic [2:0]  SP_IDX      = 3'h7;
  localparam logic [2:0]  FP_IDX      = 3'h6;
  localparam logic [15:0] WORD_STEP   = 16'h0002;

  // bus responses
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // effective address kinds
  typedef enum logic [2:0] {
    EA_GPR_IND,
    EA_ABS16,
    EA_ABS8,
    EA_CODE,
    EA_STACK
  } crf_ea_kind_t;
endpackage

// [design/crf_regfile.sv]
`timescale 1ns/10ps
module crf_regfile (
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic                 ce,
  input  wire logic                 mode_pin_max,
  input  wire logic [2:0]           rd_a_sel,
  output logic      [15:0]          rd_a_data,
  input  wire logic [2:0]           rd_b_sel,
  output logic      [15:0]          rd_b_data,
  input  wire logic                 wr_en,
  input  wire logic [2:0]           wr_sel,
  input  wire logic                 wr_byte,
  input  wire logic [15:0]          wr_data,
  input  wire logic                 sp_adj_en,
  input  wire logic                 sp_adj_dec,
  output logic      [15:0]          stack_pointer,
  output logic      [15:0]          frame_pointer,
  input  wire logic                 vec_load,
  input  wire logic [15:0]          vec_pc,
  input  wire logic [7:0]           vec_code_page,
  input  wire logic                 pc_load,
  input  wire logic [15:0]          pc_load_val,
  input  wire logic                 pc_adv,
  input  wire logic [15:0]          pc_step,
  output logic      [15:0]          program_counter,
  input  wire logic                 sr_we,
  input  wire logic [15:0]          sr_data,
  input  wire logic                 cond_we,
  input  wire logic [7:0]           cond_data,
  input  wire logic                 flag_we,
  input  wire logic                 flag_byte,
  input  wire logic [15:0]          flag_result,
  input  wire logic                 flag_ovf,
  input  wire logic                 flag_carry,
  input  wire logic                 flag_c_keep,
  output logic      [15:0]          status_word,
  output logic                      trace_pending,
  input  wire logic                 irq_req,
  input  wire logic [2:0]           irq_level,
  input  wire logic                 nmi_req,
  output logic                      irq_accept,
  input  wire logic                 irq_ack,
  input  wire logic                 page_we,
  input  wire logic [1:0]           page_sel,
  input  wire logic [7:0]           page_data,
  input  wire logic                 base_we,
  input  wire logic [7:0]           base_data,
  input  wire crf_pkg::crf_ea_kind_t ea_kind,
  input  wire logic [2:0]           ea_reg,
  input  wire logic [15:0]          ea_field,
  output logic      [23:0]          ea_addr,
  output logic                      mode_max,
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic      [1:0]           s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic      [31:0]          s_axi_rdata,
  output logic      [1:0]           s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready
);

  logic [15:0] gpr_r [crf_pkg::NUM_GPR];
  logic [7:0]  page_r [crf_pkg::NUM_PAGE];
  logic [15:0] pc_r;
  logic [15:0] sr_r;
  logic [15:0] sr_nxt;
  logic [7:0]  base_r;
  logic        mode_max_r;
  logic        rst_seen_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  logic        rvalid_r;
  logic [1:0]  rresp_r;
  logic [31:0] rdata_r;

  // byte-lane merge for bus writes
  function automatic logic [15:0] merge16(input logic [15:0] cur, input logic [31:0] wd, input logic [3:0] st);
    merge16 = {st[1] ? wd[15:8] : cur[15:8], st[0] ? wd[7:0] : cur[7:0]};
  endfunction

  // bus handshakes: write address and data taken together
  wire        wr_go    = ce && s_axi_awvalid && s_axi_wvalid && !bvalid_r;
  wire        rd_go    = ce && s_axi_arvalid && !rvalid_r;
  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign s_axi_arready = ce && !rvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rresp   = rresp_r;
  assign s_axi_rdata   = rdata_r;

  // write address decode
  wire [2:0]  aw_idx   = s_axi_awaddr[4:2];
  wire        aw_gpr   = s_axi_awaddr[7:5] == crf_pkg::OFF_GPR0[7:5] && s_axi_awaddr[1:0] == 2'h0;
  wire        aw_pc    = s_axi_awaddr == crf_pkg::OFF_PC;
  wire        aw_sr    = s_axi_awaddr == crf_pkg::OFF_SR;
  wire        aw_code  = s_axi_awaddr == crf_pkg::OFF_CODE_PG;
  wire        aw_data  = s_axi_awaddr == crf_pkg::OFF_DATA_PG;
  wire        aw_ext   = s_axi_awaddr == crf_pkg::OFF_EXT_PG;
  wire        aw_stk   = s_axi_awaddr == crf_pkg::OFF_STK_PG;
  wire        aw_base  = s_axi_awaddr == crf_pkg::OFF_BASE;
  wire        aw_page  = aw_code || aw_data || aw_ext || aw_stk;
  wire [1:0]  aw_pg    = aw_code ? crf_pkg::PG_CODE : aw_data ? crf_pkg::PG_DATA :
                         aw_ext ? crf_pkg::PG_EXT : crf_pkg::PG_STACK;
  wire        aw_hit   = aw_gpr || aw_pc || aw_sr || aw_page || aw_base;
  wire        bus_wr   = wr_go && aw_hit;

  // read decode, unmapped reads give zero with an error response
  wire [2:0]  ar_idx   = s_axi_araddr[4:2];
  wire        ar_gpr   = s_axi_araddr[7:5] == crf_pkg::OFF_GPR0[7:5] && s_axi_araddr[1:0] == 2'h0;
  wire [15:0] ar_word  = ar_gpr ? gpr_r[ar_idx] :
                         s_axi_araddr == crf_pkg::OFF_PC   ? pc_r :
                         s_axi_araddr == crf_pkg::OFF_SR   ? sr_r :
                         s_axi_araddr == crf_pkg::OFF_CODE_PG ? {8'h00, page_r[crf_pkg::PG_CODE]} :
                         s_axi_araddr == crf_pkg::OFF_DATA_PG ? {8'h00, page_r[crf_pkg::PG_DATA]} :
                         s_axi_araddr == crf_pkg::OFF_EXT_PG  ? {8'h00, page_r[crf_pkg::PG_EXT]} :
                         s_axi_araddr == crf_pkg::OFF_STK_PG  ? {8'h00, page_r[crf_pkg::PG_STACK]} :
                         s_axi_araddr == crf_pkg::OFF_BASE    ? {8'h00, base_r} :
                         s_axi_araddr == crf_pkg::OFF_MODE    ? {15'h0000, mode_max_r} : 16'h0000;
  wire        ar_hit   = s_axi_araddr[7:6] == 2'h0 && s_axi_araddr[1:0] == 2'h0; // every aligned word below 0x40

  // write response channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r  <= crf_pkg::RESP_OKAY;
    end else if (ce) begin
      if (wr_go) begin
        bvalid_r <= 1'b1;
        bresp_r  <= aw_hit ? crf_pkg::RESP_OKAY : crf_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // read data channel, data registered at the address handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rresp_r  <= crf_pkg::RESP_OKAY;
      rdata_r  <= 32'h0000_0000;
    end else if (ce) begin
      if (rd_go) begin
        rvalid_r <= 1'b1;
        rresp_r  <= ar_hit ? crf_pkg::RESP_OKAY : crf_pkg::RESP_SLVERR;
        rdata_r  <= {16'h0000, ar_word};
      end else if (s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  // mode caught on the first enabled edge after reset release
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rst_seen_r <= 1'b0;
      mode_max_r <= 1'b0;
    end else if (ce) begin
      rst_seen_r <= 1'b1;
      if (!rst_seen_r) begin
        mode_max_r <= mode_pin_max;
      end
    end
  end
  assign mode_max = mode_max_r;

  // general register write data: byte writes keep the upper half
  wire [15:0] core_wdata = wr_byte ? {gpr_r[wr_sel][15:8], wr_data[7:0]} : wr_data;
  wire [15:0] sp_step    = sp_adj_dec ? gpr_r[crf_pkg::SP_IDX] - crf_pkg::WORD_STEP
                                      : gpr_r[crf_pkg::SP_IDX] + crf_pkg::WORD_STEP;

  // general registers: core write, then stack step, then bus
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < crf_pkg::NUM_GPR; i++) begin
        gpr_r[i] <= 16'h0000;
      end
    end else if (ce) begin
      for (int i = 0; i < crf_pkg::NUM_GPR; i++) begin
        if (wr_en && wr_sel == 3'(i)) begin
          gpr_r[i] <= core_wdata;
        end else if (sp_adj_en && crf_pkg::SP_IDX == 3'(i)) begin
          gpr_r[i] <= sp_step;
        end else if (bus_wr && aw_gpr && aw_idx == 3'(i)) begin
          gpr_r[i] <= merge16(gpr_r[i], s_axi_wdata, s_axi_wstrb);
        end
      end
    end
  end

  // read ports and implicit pointers
  assign rd_a_data     = gpr_r[rd_a_sel];
  assign rd_b_data     = gpr_r[rd_b_sel];
  assign stack_pointer = gpr_r[crf_pkg::SP_IDX];
  assign frame_pointer = gpr_r[crf_pkg::FP_IDX];

  // program counter: vector, load, advance, bus
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pc_r <= 16'h0000;
    end else if (ce) begin
      if (vec_load) begin
        pc_r <= vec_pc;
      end else if (pc_load) begin
        pc_r <= pc_load_val;
      end else if (pc_adv) begin
        pc_r <= pc_r + pc_step;
      end else if (bus_wr && aw_pc) begin
        pc_r <= merge16(pc_r, s_axi_wdata, s_axi_wstrb);
      end
    end
  end
  assign program_counter = pc_r;

  // flag values from the instruction result
  wire flag_n_v = flag_byte ? flag_result[7] : flag_result[15];
  wire flag_z_v = flag_byte ? flag_result[7:0] == 8'h00 : flag_result == 16'h0000;
  wire flag_c_v = flag_c_keep ? sr_r[crf_pkg::SR_C] : flag_carry;
  wire [2:0] ack_mask = nmi_req ? crf_pkg::MASK_ALL : irq_level;

  // status word next value, later steps take priority
  always_comb begin
    sr_nxt = sr_r;
    if (bus_wr && aw_sr) begin
      sr_nxt = merge16(sr_r, s_axi_wdata, s_axi_wstrb);
    end
    if (sr_we) begin
      sr_nxt = sr_data;
    end
    if (cond_we) begin
      sr_nxt[7:0] = cond_data;
    end
    if (flag_we) begin
      sr_nxt[crf_pkg::SR_N] = flag_n_v;
      sr_nxt[crf_pkg::SR_Z] = flag_z_v;
      sr_nxt[crf_pkg::SR_V] = flag_ovf;
      sr_nxt[crf_pkg::SR_C] = flag_c_v;
    end
    if (irq_ack) begin
      sr_nxt[crf_pkg::SR_MASK_LO +: 3] = ack_mask;
    end
    sr_nxt = sr_nxt & crf_pkg::SR_WMASK;
  end

  // status word register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sr_r <= crf_pkg::SR_RESET;
    end else if (ce) begin
      sr_r <= sr_nxt;
    end
  end
  assign status_word   = sr_r;
  assign trace_pending = sr_r[crf_pkg::SR_TRACE];

  // interrupt acceptance against the mask
  wire [2:0] mask_lvl = sr_r[crf_pkg::SR_MASK_LO +: 3];
  assign irq_accept   = nmi_req || (irq_req && irq_level > mask_lvl);

  // page registers and base register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < crf_pkg::NUM_PAGE; i++) begin
        page_r[i] <= 8'h00;
      end
      base_r <= 8'h00;
    end else if (ce) begin
      for (int i = 0; i < crf_pkg::NUM_PAGE; i++) begin
        if (vec_load && mode_max_r && crf_pkg::PG_CODE == 2'(i)) begin
          page_r[i] <= vec_code_page;
        end else if (page_we && page_sel == 2'(i)) begin
          page_r[i] <= page_data;
        end else if (bus_wr && aw_page && aw_pg == 2'(i) && s_axi_wstrb[0]) begin
          page_r[i] <= s_axi_wdata[7:0];
        end
      end
      if (base_we) begin
        base_r <= base_data;
      end else if (bus_wr && aw_base && s_axi_wstrb[0]) begin
        base_r <= s_axi_wdata[7:0];
      end
    end
  end

  // page chosen for register indirect addressing
  wire [7:0]  ind_page = ea_reg[2] == 1'b0 ? page_r[crf_pkg::PG_DATA] :
                         ea_reg[1] == 1'b0 ? page_r[crf_pkg::PG_EXT] :
                                             page_r[crf_pkg::PG_STACK];
  // effective address forming
  wire [23:0] ea_raw   = ea_kind == crf_pkg::EA_GPR_IND ? {ind_page, gpr_r[ea_reg]} :
                         ea_kind == crf_pkg::EA_ABS16   ? {page_r[crf_pkg::PG_DATA], ea_field} :
                         ea_kind == crf_pkg::EA_ABS8    ? {8'h00, base_r, ea_field[7:0]} :
                         ea_kind == crf_pkg::EA_CODE    ? {page_r[crf_pkg::PG_CODE], pc_r} :
                                                          {page_r[crf_pkg::PG_STACK], gpr_r[crf_pkg::SP_IDX]};
  assign ea_addr = mode_max_r ? ea_raw : {8'h00, ea_raw[15:0]};

  // helpers for checks
  wire [7:0] wr_upper = gpr_r[wr_sel][15:8];

  sequence s_byte_wr;
    ce && wr_en && wr_byte;
  endsequence
  property p_byte_keep;
    @(posedge aclk) disable iff (!aresetn)
      s_byte_wr |=> gpr_r[$past(wr_sel)][15:8] == $past(wr_upper);
  endproperty
  a_byte_keep: assert property (p_byte_keep) else $error("byte write changed upper half");

  sequence s_sp_step;
    ce && sp_adj_en && !(wr_en && wr_sel == crf_pkg::SP_IDX);
  endsequence
  property p_sp_step;
    @(posedge aclk) disable iff (!aresetn)
      s_sp_step |=> stack_pointer == ($past(sp_adj_dec) ? $past(stack_pointer) - 16'h0002
                                                         : $past(stack_pointer) + 16'h0002);
  endproperty
  a_sp_step: assert property (p_sp_step) else $error("stack pointer step wrong");

  property p_sr_reserved;
    @(posedge aclk) disable iff (!aresetn)
      (status_word & ~crf_pkg::SR_WMASK) == 16'h0000;
  endproperty
  a_sr_reserved: assert property (p_sr_reserved) else $error("reserved status bits nonzero");

  property p_mask_block;
    @(posedge aclk) disable iff (!aresetn)
      irq_req && !nmi_req && irq_level <= mask_lvl |-> !irq_accept;
  endproperty
  a_mask_block: assert property (p_mask_block) else $error("masked request accepted");

  property p_nmi_take;
    @(posedge aclk) disable iff (!aresetn)
      nmi_req |-> irq_accept ##1 (!$past(ce) || !$past(irq_ack) || mask_lvl == 3'h7);
  endproperty
  a_nmi_take: assert property (p_nmi_take) else $error("nonmaskable handling wrong");

  property p_reset_sr;
    @(posedge aclk) disable iff (!aresetn)
      $rose(aresetn) |-> status_word[15:8] == 8'h07;
  endproperty
  a_reset_sr: assert property (p_reset_sr) else $error("status upper byte not 07 after reset");

  property p_zero_flag;
    @(posedge aclk) disable iff (!aresetn)
      ce && flag_we && (flag_byte ? flag_result[7:0] == 8'h00 : flag_result == 16'h0000)
      |=> status_word[2] && !status_word[3];
  endproperty
  a_zero_flag: assert property (p_zero_flag) else $error("zero flag not set");

  property p_short_abs;
    @(posedge aclk) disable iff (!aresetn)
      ea_kind == crf_pkg::EA_ABS8 |-> ea_addr == {8'h00, base_r, ea_field[7:0]};
  endproperty
  a_short_abs: assert property (p_short_abs) else $error("short absolute address wrong");

  property p_min_mode;
    @(posedge aclk) disable iff (!aresetn)
      !mode_max_r |-> ea_addr[23:16] == 8'h00;
  endproperty
  a_min_mode: assert property (p_min_mode) else $error("page used in minimum mode");

  property p_mode_hold;
    @(posedge aclk) disable iff (!aresetn)
      rst_seen_r |=> $stable(mode_max_r);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode changed after latch");

endmodule

// [testbench/crf_irq_model.sv]
`timescale 1ns/10ps
// interrupt source: posts a request, acknowledges it once accepted
module crf_irq_model (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       irq_accept,
  output logic            irq_req,
  output logic [2:0]      irq_level,
  output logic            nmi_req,
  output logic            irq_ack
);
  // quiet at time zero
  initial begin
    irq_req = 1'b0;
    nmi_req = 1'b0;
    irq_level = 3'h0;
    irq_ack = 1'b0;
  end
  // one ack per accepted request, then withdraw it
  always @(posedge aclk) begin
    if (!aresetn) begin
      irq_ack <= 1'b0;
    end else if (irq_ack) begin
      irq_ack <= 1'b0;
      irq_req <= 1'b0;
      nmi_req <= 1'b0;
    end else if (irq_accept && (irq_req || nmi_req)) begin
      irq_ack <= 1'b1;
    end
  end
  // raise or drop a request just after an edge
  task automatic post(input logic r, input logic n, input logic [2:0] l);
    @(posedge aclk);
    irq_req <= r;
    nmi_req <= n;
    irq_level <= l;
  endtask
endmodule

// [testbench/cpu_register_file_paging_tb.sv]
`timescale 1ns/10ps
module cpu_register_file_paging_tb;
  logic        aclk, irq_req, nmi_req, irq_accept, irq_ack, trace_pending, mode_max;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        aresetn = 0, ce = 1, mode_pin_max = 0, wr_byte = 0, sp_adj_dec = 0, flag_byte = 0;
  logic        flag_ovf = 0, flag_carry = 0, flag_c_keep = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
  logic        s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  wire         wr_en, sp_adj_en, vec_load, pc_load, pc_adv, sr_we, cond_we, flag_we, page_we, base_we;
  logic [9:0]  stb = 0;
  logic [1:0]  page_sel = 0, s_axi_bresp, s_axi_rresp;
  logic [2:0]  rd_a_sel = 0, rd_b_sel = 0, wr_sel = 0, ea_reg = 0, irq_level;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [7:0]  vec_code_page = 8'hC3, cond_data = 0, page_data = 0, base_data = 0;
  logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [15:0] vec_pc = 16'h0100, pc_load_val = 16'h4000, pc_step = 16'h0002;
  logic [15:0] wr_data = 0, sr_data = 0, flag_result = 0, ea_field = 0;
  logic [15:0] rd_a_data, rd_b_data, stack_pointer, frame_pointer, program_counter, status_word;
  logic [23:0] ea_addr;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  crf_pkg::crf_ea_kind_t ea_kind = crf_pkg::EA_GPR_IND;
  int          fail_count = 0, n_checks = 0;
  localparam logic [9:0] S_WR = 10'h200, S_SP = 10'h100, S_VEC = 10'h080, S_PCL = 10'h040, S_PCA = 10'h020;
  localparam logic [9:0] S_SR = 10'h010, S_CND = 10'h008, S_FLG = 10'h004, S_PG = 10'h002, S_BASE = 10'h001;

  // core strobes share one vector
  assign {wr_en, sp_adj_en, vec_load, pc_load, pc_adv, sr_we, cond_we, flag_we, page_we, base_we} = stb;
  crf_regfile u_crf_regfile (.*);
  crf_irq_model u_crf_irq_model (.aclk, .aresetn, .irq_accept, .irq_req, .irq_level, .nmi_req, .irq_ack);

  // clock and hang guard
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  initial begin
    repeat (20000) @(posedge aclk);
    $display("[ERR] run exp done got hang");
    fail_count++;
    close_out();
  end

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s exp %h got %h", what, exp, got);
    end
  endtask
  // bounded wait for a handshake, sampled where settled
  task automatic wait_hi(ref logic s, input string what);
    int i = 0;
    do @(negedge aclk); while (s !== 1'b1 && ++i < 50);
    if (s !== 1'b1) begin
      fail_count++;
      $display("[ERR] %s exp 1 got %b", what, s);
      close_out();
    end
  endtask
  task automatic pulse(input logic [9:0] m);
    stb <= m;
    @(posedge aclk);
    stb <= 10'h000;
    @(negedge aclk);
  endtask
  task automatic do_reset(input logic mx);
    @(posedge aclk);
    mode_pin_max <= mx;
    aresetn <= 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    @(negedge aclk);
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    wait_hi(s_axi_awready, "awready");
    @(posedge aclk);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    wait_hi(s_axi_bvalid, "bvalid");
    chk("bresp", er, s_axi_bresp);
    @(posedge aclk);
    s_axi_bready <= 1'b0;
    @(negedge aclk);
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    wait_hi(s_axi_arready, "arready");
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    wait_hi(s_axi_rvalid, "rvalid");
    chk("rresp", er, s_axi_rresp);
    chk("rdata", ed, s_axi_rdata);
    @(posedge aclk);
    s_axi_rready <= 1'b0;
    @(negedge aclk);
  endtask
  task automatic flg(input logic [15:0] r, input logic v, c, k, b);
    @(posedge aclk);
    flag_result <= r;
    flag_ovf <= v;
    flag_carry <= c;
    flag_c_keep <= k;
    flag_byte <= b;
    pulse(S_FLG);
  endtask
  task automatic sr_set(input logic [15:0] d);
    @(posedge aclk);
    sr_data <= d;
    pulse(S_SR);
  endtask
  task automatic ea(input crf_pkg::crf_ea_kind_t k, input logic [2:0] r, input logic [15:0] f);
    @(posedge aclk);
    ea_kind <= k;
    ea_reg <= r;
    ea_field <= f;
    @(negedge aclk);
  endtask

  // main sequence
  initial begin
    do_reset(1'b0);
    chk("status_word", 16'h0700, status_word);
    chk("trace_pending", 1'b0, trace_pending);
    chk("mode_max", 1'b0, mode_max);
    axi_wr(crf_pkg::OFF_SR, 32'h0000FFFF, crf_pkg::RESP_OKAY);
    axi_rd(crf_pkg::OFF_SR, 32'h0000870F, crf_pkg::RESP_OKAY);
    chk("trace_pending", 1'b1, trace_pending);
    @(posedge aclk);
    cond_data <= 8'hA5;
    pulse(S_CND);
    chk("status_word", 16'h8705, status_word);
    flg(16'h8000, 1'b1, 1'b1, 1'b0, 1'b0);
    chk("status_word", 16'h870B, status_word);
    flg(16'h0001, 1'b0, 1'b0, 1'b1, 1'b0);
    chk("status_word", 16'h8701, status_word);
    flg(16'h0100, 1'b0, 1'b1, 1'b0, 1'b1);
    chk("status_word", 16'h8705, status_word);
    sr_set(16'h0300);
    chk("trace_pending", 1'b0, trace_pending);
    $display("test status done");
    u_crf_irq_model.post(1'b1, 1'b0, 3'h3);
    repeat (3) @(negedge aclk);
    chk("irq_accept", 1'b0, irq_accept);
    u_crf_irq_model.post(1'b1, 1'b0, 3'h4);
    @(negedge aclk);
    chk("irq_accept", 1'b1, irq_accept);
    repeat (3) @(negedge aclk);
    chk("status_word", 16'h0400, status_word);
    sr_set(16'h0200);
    u_crf_irq_model.post(1'b0, 1'b1, 3'h0);
    @(negedge aclk);
    chk("irq_accept", 1'b1, irq_accept);
    repeat (3) @(negedge aclk);
    chk("status_word", 16'h0700, status_word);
    $display("test interrupt done");
    for (int n = 0; n < 8; n++) begin
      @(posedge aclk);
      wr_sel <= 3'(n);
      wr_data <= 16'hA000 + 16'(n);
      pulse(S_WR);
    end
    for (int n = 0; n < 8; n++) begin
      @(posedge aclk);
      rd_a_sel <= 3'(n);
      rd_b_sel <= 3'(7 - n);
      @(negedge aclk);
      chk("rd_a_data", 16'hA000 + 16'(n), rd_a_data);
      chk("rd_b_data", 16'hA007 - 16'(n), rd_b_data);
    end
    chk("frame_pointer", 16'hA006, frame_pointer);
    @(posedge aclk);
    wr_sel <= 3'h3;
    wr_byte <= 1'b1;
    wr_data <= 16'h55AB;
    pulse(S_WR);
    axi_rd(crf_pkg::OFF_GPR0 + 8'h0C, 32'h0000A0AB, crf_pkg::RESP_OKAY);
    axi_wr(crf_pkg::OFF_GPR0 + 8'h1C, 32'h00001000, crf_pkg::RESP_OKAY);
    @(posedge aclk);
    sp_adj_dec <= 1'b1;
    pulse(S_SP);
    chk("stack_pointer", 16'h0FFE, stack_pointer);
    @(posedge aclk);
    sp_adj_dec <= 1'b0;
    pulse(S_SP);
    chk("stack_pointer", 16'h1000, stack_pointer);
    $display("test general done");
    @(posedge aclk);
    pulse(S_VEC);
    chk("program_counter", 16'h0100, program_counter);
    axi_rd(crf_pkg::OFF_CODE_PG, 32'h00000000, crf_pkg::RESP_OKAY);
    @(posedge aclk);
    pulse(S_PCA);
    chk("program_counter", 16'h0102, program_counter);
    @(posedge aclk);
    pulse(S_PCL | S_PCA);
    chk("program_counter", 16'h4000, program_counter);
    @(posedge aclk);
    ce <= 1'b0;
    pulse(S_PCA);
    chk("program_counter", 16'h4000, program_counter);
    @(posedge aclk);
    ce <= 1'b1;
    axi_wr(crf_pkg::OFF_DATA_PG, 32'h00000022, crf_pkg::RESP_OKAY);
    ea(crf_pkg::EA_ABS16, 3'h0, 16'h1234);
    chk("ea_addr", 24'h001234, ea_addr);
    $display("test minimum done");
    @(posedge aclk);
    vec_code_page <= 8'h5A;
    do_reset(1'b1);
    chk("mode_max", 1'b1, mode_max);
    @(posedge aclk);
    pulse(S_VEC);
    ea(crf_pkg::EA_CODE, 3'h0, 16'h0000);
    chk("ea_addr", 24'h5A0100, ea_addr);
    for (int n = 0; n < 4; n++) begin
      @(posedge aclk);
      page_sel <= 2'(n);
      page_data <= 8'(8'h11 * (n + 1));
      pulse(S_PG);
    end
    @(posedge aclk);
    base_data <= 8'h7C;
    pulse(S_BASE);
    for (int r = 0; r < 8; r++) begin
      ea(crf_pkg::EA_GPR_IND, 3'(r), 16'h0000);
      chk("ea_page", (r < 4) ? 8'h22 : (r < 6) ? 8'h33 : 8'h44, ea_addr[23:16]);
    end
    ea(crf_pkg::EA_ABS16, 3'h0, 16'hBEEF);
    chk("ea_addr", 24'h22BEEF, ea_addr);
    ea(crf_pkg::EA_ABS8, 3'h0, 16'h1233);
    chk("ea_addr", 24'h007C33, ea_addr);
    ea(crf_pkg::EA_STACK, 3'h7, 16'h0000);
    chk("ea_page", 8'h44, ea_addr[23:16]);
    axi_rd(crf_pkg::OFF_STK_PG, 32'h00000044, crf_pkg::RESP_OKAY);
    axi_rd(crf_pkg::OFF_MODE, 32'h00000001, crf_pkg::RESP_OKAY);
    axi_wr(crf_pkg::OFF_MODE, 32'h00000000, crf_pkg::RESP_SLVERR);
    axi_rd(8'h40, 32'h00000000, crf_pkg::RESP_SLVERR);
    $display("test maximum done");
    close_out();
  end
endmodule
